/* common/fldr_pkg.sv */
package fldr_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_RETRY     = 8'h04;
  localparam logic [7:0] ADDR_INTERVAL  = 8'h08;
  localparam logic [7:0] ADDR_CHANNEL   = 8'h0C;
  localparam logic [7:0] ADDR_MAXFREQ   = 8'h10;
  localparam logic [7:0] ADDR_LEVEL_A   = 8'h14;
  localparam logic [7:0] ADDR_LAG_A     = 8'h18;
  localparam logic [7:0] ADDR_LEVEL_B   = 8'h1C;
  localparam logic [7:0] ADDR_LAG_B     = 8'h20;
  localparam logic [7:0] ADDR_STATUS    = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h28;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h30;
  localparam logic [7:0] ADDR_RETRY_CNT = 8'h34;

  // Reset values and limits
  localparam logic [3:0]  RETRY_LIMIT_RST = 4'h0;
  localparam logic [15:0] INTERVAL_RST    = 16'h000A;   // 1.0 s in 0.1 s units
  localparam logic [7:0]  CHANNEL_RST     = 8'h00;
  localparam logic [15:0] MAXFREQ_RST     = 16'h1388;   // 50.00 Hz, plain default
  localparam logic [15:0] LEVEL_A_RST     = 16'h0000;
  localparam logic [15:0] LEVEL_B_RST     = 16'h1388;
  localparam logic [9:0]  LAG_RST         = 10'h032;    // 5.0 % in 0.1 % units
  localparam logic [9:0]  LAG_MAX         = 10'h3E8;    // 100.0 %
  localparam logic [3:0]  RETRY_LIMIT_MAX = 4'hA;
  localparam logic [3:0]  CHAN_SRC_MAX    = 4'h5;

  // Timing
  localparam int TENTH_SEC_NS   = 100_000_000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TENTH_CYCLES   = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam int QUIET_SEC      = 600;
  localparam int QUIET_TENTHS   = QUIET_SEC * 10;

  // Interrupt bit positions
  localparam int IRQ_DET_A = 0;
  localparam int IRQ_DET_B = 1;
  localparam int IRQ_RETRY = 2;
  localparam int IRQ_TRIP  = 3;
  localparam int IRQ_W     = 4;

  typedef enum logic [1:0] {
    FLDR_IDLE = 2'b00,
    FLDR_WAIT = 2'b01,
    FLDR_TRIP = 2'b11
  } fldr_state_t;
endpackage : fldr_pkg

/* hw/fldr_top.sv */
`timescale 1ns/1ps
// Function
// - Consecutive automatic fault resets are counted and a fault arriving once the count has reached the limit trips the drive and stops it.
// - The reset count clears after 600 s of running from start with no fault.
// - An automatic fault reset only takes effect after the reset interval from the fault has elapsed.
// - The ones digit of the channel setting selects the switchover command source, 5 being reserved.
// - Switchover while running is allowed only when the tens digit of the channel setting is 1.
// - The detection flag rises once output frequency exceeds the first detector level and stays high.
// - The flag only falls once output frequency drops below level minus lag.
// - The lag is a percentage of the detector's own level, default five percent.
// - A second independent detector has its own level and lag with the same behaviour.
module fldr_top
  import fldr_pkg::*;
#(
  parameter int TENTH_CYC = TENTH_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] out_freq,
  input  wire logic        fault_event,
  input  wire logic        running,
  input  wire logic        switch_req_term,
  input  wire logic        switch_req_modbus,
  input  wire logic        switch_req_bus,
  input  wire logic        switch_req_eth,
  input  wire logic        switch_req_ind,
  output logic             freq_level_detector_a,
  output logic             freq_level_detector_b,
  output logic             fault_reset,
  output logic             fault_trip,
  output logic             motor_switch,
  output logic             irq
);

  logic [3:0]  retry_limit_r;
  logic [15:0] interval_r;
  logic [7:0]  channel_r;
  logic [15:0] maxfreq_r;
  logic [15:0] level_r [2];
  logic [9:0]  lag_r [2];
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_evt;
  logic [3:0]  retry_cnt_r;
  logic [1:0]  det_r;
  logic [1:0]  det_q_r;
  logic        trip_clr;
  fldr_state_t state_r;

  // Two-stage synchronisers for pin inputs
  logic [7:0] meta_r;
  logic [7:0] sync_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end else begin
      meta_r <= {switch_req_ind, switch_req_eth, switch_req_bus, switch_req_modbus,
                 switch_req_term, running, fault_event, 1'b0};
      sync_r <= meta_r;
    end
  end
  logic fault_s, run_s;
  assign fault_s = sync_r[1];
  assign run_s   = sync_r[2];

  function automatic logic [15:0] clamp_lvl(input logic [15:0] v, input logic [15:0] mx);
    clamp_lvl = (v > mx) ? mx : v;
  endfunction : clamp_lvl

  function automatic logic [9:0] clamp_lag(input logic [9:0] v);
    clamp_lag = (v > LAG_MAX) ? LAG_MAX : v;
  endfunction : clamp_lag

  // Register writes: one process per register
  logic       wr_ctrl;
  logic       wr_retry;
  logic       wr_interval;
  logic       wr_channel;
  logic       wr_maxfreq;
  logic       wr_irq_en;
  logic [1:0] wr_level;
  logic [1:0] wr_lag;
  assign wr_ctrl     = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_retry    = reg_wr && (reg_addr == ADDR_RETRY);
  assign wr_interval = reg_wr && (reg_addr == ADDR_INTERVAL);
  assign wr_channel  = reg_wr && (reg_addr == ADDR_CHANNEL);
  assign wr_maxfreq  = reg_wr && (reg_addr == ADDR_MAXFREQ);
  assign wr_irq_en   = reg_wr && (reg_addr == ADDR_IRQ_EN);
  assign wr_level    = {reg_wr && (reg_addr == ADDR_LEVEL_B), reg_wr && (reg_addr == ADDR_LEVEL_A)};
  assign wr_lag      = {reg_wr && (reg_addr == ADDR_LAG_B), reg_wr && (reg_addr == ADDR_LAG_A)};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_clr <= 1'b0;
    end else begin
      trip_clr <= wr_ctrl & reg_wdata[0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      retry_limit_r <= RETRY_LIMIT_RST;
    end else if (wr_retry) begin
      retry_limit_r <= (reg_wdata[3:0] > RETRY_LIMIT_MAX) ? RETRY_LIMIT_MAX : reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      interval_r <= INTERVAL_RST;
    end else if (wr_interval) begin
      interval_r <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_r <= CHANNEL_RST;
    end else if (wr_channel) begin
      channel_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      maxfreq_r <= MAXFREQ_RST;
    end else if (wr_maxfreq) begin
      maxfreq_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_r <= '0;
    end else if (wr_irq_en) begin
      irq_en_r <= reg_wdata[IRQ_W-1:0];
    end
  end

  genvar gr;
  generate
    for (gr = 0; gr < 2; gr++) begin : g_cfg
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          level_r[gr] <= (gr == 0) ? LEVEL_A_RST : LEVEL_B_RST;
        end else if (wr_level[gr]) begin
          level_r[gr] <= reg_wdata[15:0];
        end
      end
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          lag_r[gr] <= LAG_RST;
        end else if (wr_lag[gr]) begin
          lag_r[gr] <= clamp_lag(reg_wdata[9:0]);
        end
      end
    end
  endgenerate

  // Frequency-level detectors with hysteresis
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_det
      logic [15:0] lvl;
      logic [25:0] lag_prod;
      logic [15:0] lag_hz;
      logic [15:0] low_thr;
      assign lvl      = clamp_lvl(level_r[gi], maxfreq_r);
      assign lag_prod = lvl * lag_r[gi];
      assign lag_hz   = 16'(lag_prod / 26'd1000);
      assign low_thr  = lvl - lag_hz;
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          det_r[gi] <= 1'b0;
        end else if (out_freq > lvl) begin
          det_r[gi] <= 1'b1;
        end else if (out_freq < low_thr) begin
          det_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      det_q_r               <= 2'b00;
      freq_level_detector_a <= 1'b0;
      freq_level_detector_b <= 1'b0;
    end else begin
      det_q_r               <= det_r;
      freq_level_detector_a <= det_r[0];
      freq_level_detector_b <= det_r[1];
    end
  end

  // 0.1 s time base
  logic [31:0] tick_cnt_r;
  logic        tick;
  assign tick = (tick_cnt_r == 32'(TENTH_CYC - 1));
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'd1;
    end
  end

  // Fault retry supervisor
  logic        fault_q_r;
  logic        fault_rise;
  logic [15:0] wait_r;
  logic [15:0] quiet_r;
  logic        retry_evt;
  logic        trip_evt;
  assign fault_rise = fault_s & ~fault_q_r;
  // Whole ticks only, so the first partial tick never shortens the interval
  assign retry_evt  = (state_r == FLDR_WAIT) && tick && (wait_r >= interval_r);
  assign trip_evt   = (state_r == FLDR_IDLE) && fault_rise && (retry_cnt_r >= retry_limit_r);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_q_r   <= 1'b0;
      state_r     <= FLDR_IDLE;
      wait_r      <= '0;
      retry_cnt_r <= '0;
      fault_reset <= 1'b0;
      fault_trip  <= 1'b0;
    end else begin
      fault_q_r   <= fault_s;
      fault_reset <= 1'b0;
      unique case (state_r)
        FLDR_IDLE: begin
          wait_r <= '0;
          if (fault_rise) begin
            if (trip_evt) begin
              state_r    <= FLDR_TRIP;
              fault_trip <= 1'b1;
            end else begin
              state_r <= FLDR_WAIT;
            end
          end else if (run_s && quiet_r == 16'(QUIET_TENTHS)) begin
            retry_cnt_r <= '0;
          end
        end
        FLDR_WAIT: begin
          if (tick) wait_r <= wait_r + 16'd1;
          if (retry_evt) begin
            state_r     <= FLDR_IDLE;
            fault_reset <= 1'b1;
            retry_cnt_r <= retry_cnt_r + 4'd1;
          end
        end
        FLDR_TRIP: begin
          if (trip_clr) begin
            state_r     <= FLDR_IDLE;
            fault_trip  <= 1'b0;
            retry_cnt_r <= '0;
          end
        end
        default: state_r <= FLDR_IDLE;
      endcase
    end
  end

  // Fault-free running time since start
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_r <= '0;
    end else if (!run_s || fault_s || state_r != FLDR_IDLE) begin
      quiet_r <= '0;
    end else if (tick && quiet_r != 16'(QUIET_TENTHS)) begin
      quiet_r <= quiet_r + 16'd1;
    end
  end

  // Motor switchover
  logic sel_req;
  always_comb begin
    unique case (channel_r[3:0])
      4'h0:    sel_req = sync_r[3];
      4'h1:    sel_req = sync_r[4];
      4'h2:    sel_req = sync_r[5];
      4'h3:    sel_req = sync_r[6];
      4'h4:    sel_req = sync_r[7];
      default: sel_req = 1'b0;
    endcase
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      motor_switch <= 1'b0;
    end else if (!run_s || channel_r[7:4] == 4'h1) begin
      motor_switch <= sel_req;
    end
  end

  // Interrupts: set wins over clear
  assign irq_evt = {trip_evt, retry_evt, det_r[1] & ~det_q_r[1], det_r[0] & ~det_q_r[0]};
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
    end else if (reg_wr && reg_addr == ADDR_IRQ_CLR) begin
      irq_stat_r <= (irq_stat_r & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RETRY:     reg_rdata <= {28'h000_0000, retry_limit_r};
        ADDR_INTERVAL:  reg_rdata <= {16'h0000, interval_r};
        ADDR_CHANNEL:   reg_rdata <= {24'h00_0000, channel_r};
        ADDR_MAXFREQ:   reg_rdata <= {16'h0000, maxfreq_r};
        ADDR_LEVEL_A:   reg_rdata <= {16'h0000, level_r[0]};
        ADDR_LAG_A:     reg_rdata <= {22'h00_0000, lag_r[0]};
        ADDR_LEVEL_B:   reg_rdata <= {16'h0000, level_r[1]};
        ADDR_LAG_B:     reg_rdata <= {22'h00_0000, lag_r[1]};
        ADDR_STATUS:    reg_rdata <= {26'h000_0000, motor_switch, state_r, fault_trip, det_r};
        ADDR_IRQ_STAT:  reg_rdata <= {28'h000_0000, irq_stat_r};
        ADDR_IRQ_EN:    reg_rdata <= {28'h000_0000, irq_en_r};
        ADDR_RETRY_CNT: reg_rdata <= {28'h000_0000, retry_cnt_r};
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : fldr_top

/* verif/fldr_drive_model.sv */
`timescale 1ns/1ps
module fldr_drive_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        run_cmd,
  input  wire logic        flt_inj,
  input  wire logic [15:0] freq_set,
  input  wire logic        fault_reset,
  input  wire logic        fault_trip,
  output logic             fault_event,
  output logic             running,
  output logic      [15:0] out_freq
);
  // Fault stays raised until the block resets it or trips
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) fault_event <= 1'b0;
    else if (flt_inj) fault_event <= 1'b1;
    else if (fault_reset || fault_trip) fault_event <= 1'b0;
  end
  assign running  = run_cmd && !fault_event && !fault_trip;
  assign out_freq = running ? freq_set : 16'h0000;
endmodule : fldr_drive_model

/* verif/fldr_props.sv */
`timescale 1ns/1ps
module fldr_props
  import fldr_pkg::*;
#(
  parameter int TENTH_CYC = 10
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] out_freq,
  input wire logic        fault_event,
  input wire logic        running,
  input wire logic        freq_level_detector_a,
  input wire logic        freq_level_detector_b,
  input wire logic        fault_reset,
  input wire logic        fault_trip,
  input wire logic        motor_switch,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] run_cnt;
  logic       chan_run;
  logic       flt_q;
  int         since;
  // Consecutive running cycles, whether the tens digit of the channel is 1, cycles since the last fault rise
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_cnt  <= 4'h0;
      chan_run <= 1'b0;
      flt_q    <= 1'b0;
      since    <= 0;
    end else begin
      run_cnt  <= !running ? 4'h0 : (run_cnt == 4'hF ? run_cnt : run_cnt + 4'h1);
      chan_run <= (reg_wr && reg_addr == ADDR_CHANNEL) ? (reg_wdata[7:4] == 4'h1) : chan_run;
      flt_q    <= fault_event;
      since    <= (fault_event && !flt_q) ? 0 : (since > 100000 ? since : since + 1);
    end
  end
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rst_pulse; fault_reset |=> !fault_reset; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("fault reset longer than one cycle");
  property p_rst_wait; fault_reset |-> since >= TENTH_CYC; endproperty
  a_rst_wait: assert property (p_rst_wait) else $error("fault reset before interval");
  property p_trip_no_rst; fault_trip |-> !fault_reset; endproperty
  a_trip_no_rst: assert property (p_trip_no_rst) else $error("reset while tripped");
  property p_trip_hold; fault_trip && !(reg_wr && reg_addr == ADDR_CTRL && reg_wdata[0])
    && !$past(reg_wr && reg_addr == ADDR_CTRL && reg_wdata[0]) |=> fault_trip; endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip dropped uncleared");
  property p_det_a; $rose(freq_level_detector_a) |-> ($past(out_freq, 1) | $past(out_freq, 2) | $past(out_freq, 3)) != 0;
  endproperty
  a_det_a: assert property (p_det_a) else $error("detector a set at zero frequency");
  property p_det_b; $rose(freq_level_detector_b) |-> ($past(out_freq, 1) | $past(out_freq, 2) | $past(out_freq, 3)) != 0;
  endproperty
  a_det_b: assert property (p_det_b) else $error("detector b set at zero frequency");
  property p_sw_hold; run_cnt >= 4'h6 && !chan_run |=> $stable(motor_switch); endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("switchover changed while running");
  property p_irq_off; reg_wr && reg_addr == ADDR_IRQ_EN && reg_wdata[3:0] == 4'h0 |-> ##2 !irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt high with all enables off");
endmodule : fldr_props
bind fldr_top fldr_props #(.TENTH_CYC(TENTH_CYC)) u_fldr_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .out_freq(out_freq), .fault_event(fault_event), .running(running), .freq_level_detector_a(freq_level_detector_a),
  .freq_level_detector_b(freq_level_detector_b), .fault_reset(fault_reset), .fault_trip(fault_trip),
  .motor_switch(motor_switch), .irq(irq));

/* verif/freq_level_detect_fault_retry_tb_top.sv */
`timescale 1ns/1ps
module freq_level_detect_fault_retry_tb_top;
  import fldr_pkg::*;
  localparam int TC = 10;
  localparam logic [7:0] RA [9] = '{ADDR_RETRY, ADDR_INTERVAL, ADDR_CHANNEL, ADDR_MAXFREQ, ADDR_LEVEL_A,
    ADDR_LAG_A, ADDR_LEVEL_B, ADDR_LAG_B, 8'hFC};
  localparam logic [31:0] RV [9] = '{0, 10, 0, 5000, 0, 50, 5000, 50, 0};
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [4:0]  sw_req = 5'h00;
  logic        run_cmd = 1'b0;
  logic        flt_inj = 1'b0;
  logic [15:0] freq_set = 16'h0000;
  logic [31:0] reg_rdata;
  logic [15:0] out_freq;
  logic        fault_event, running, det_a, det_b, f_rst, f_trip, m_sw, irq, ea, eb;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seed = 32'he778_9b93;
  int          lva, lga, lvb, lgb, f, n, w;
  always #5 sys_clk = ~sys_clk;
  fldr_top #(.TENTH_CYC(TC)) u_fldr_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_freq(out_freq),
    .fault_event(fault_event), .running(running), .switch_req_term(sw_req[0]), .switch_req_modbus(sw_req[1]),
    .switch_req_bus(sw_req[2]), .switch_req_eth(sw_req[3]), .switch_req_ind(sw_req[4]),
    .freq_level_detector_a(det_a), .freq_level_detector_b(det_b), .fault_reset(f_rst), .fault_trip(f_trip),
    .motor_switch(m_sw), .irq(irq));
  fldr_drive_model u_fldr_drive_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .run_cmd(run_cmd),
    .flt_inj(flt_inj), .freq_set(freq_set), .fault_reset(f_rst), .fault_trip(f_trip),
    .fault_event(fault_event), .running(running), .out_freq(out_freq));
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask : rd
  // Injects one fault and counts cycles until a reset pulse or a trip
  task automatic flt();
    @(posedge sys_clk);
    flt_inj <= 1'b1;
    @(posedge sys_clk);
    flt_inj <= 1'b0;
    for (w = 0; w < 200 && f_rst !== 1'b1 && f_trip !== 1'b1; w++) cyc(1);
  endtask : flt
  function automatic logic hys(logic p, int fq, int lv, int lg);
    if (fq > lv) return 1'b1;
    if (fq < lv - lv * lg / 1000) return 1'b0;
    return p;
  endfunction : hys
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 70000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    cyc(8);
    sys_rst <= 1'b0;
    foreach (RA[i]) rd(RA[i], RV[i]);
    lva = 1000 + {$random(seed)} % 3000;
    lga = {$random(seed)} % 1001;
    lvb = 1000 + {$random(seed)} % 3000;
    lgb = {$random(seed)} % 1001;
    wr(ADDR_LEVEL_A, lva);
    wr(ADDR_LAG_A, lga);
    wr(ADDR_LEVEL_B, lvb);
    wr(ADDR_LAG_B, lgb);
    run_cmd <= 1'b1;
    ea = 1'b0;
    eb = 1'b0;
    for (n = 0; n < 40; n++) begin
      f = n == 0 ? lva + 1 : n == 1 ? lva : n == 2 ? lva - lva * lga / 1000 : n == 3 ? (f > 0 ? f - 1 : 0)
        : {$random(seed)} % 5001;
      freq_set <= f[15:0];
      cyc(6);
      ea = hys(ea, f, lva, lga);
      eb = hys(eb, f, lvb, lgb);
      chk("det_a", det_a, ea);
      chk("det_b", det_b, eb);
    end
    wr(ADDR_LAG_B, 0);
    wr(ADDR_LEVEL_B, 6000);
    freq_set <= 16'h0000;
    cyc(6);
    chk("det_b", det_b, 1'b0);
    freq_set <= 16'd5001;
    cyc(6);
    chk("det_b", det_b, 1'b1);
    freq_set <= 16'h0000;
    wr(ADDR_IRQ_CLR, 32'h0000_000F);
    wr(ADDR_RETRY, 2);
    wr(ADDR_INTERVAL, 3);
    wr(ADDR_IRQ_EN, 32'h0000_0008);
    for (n = 0; n < 2; n++) begin
      flt();
      chk("reset_pulse", f_rst, 1'b1);
      chk("reset_wait", w >= 3 * TC && w <= 4 * TC + 8, 1'b1);
      rd(ADDR_RETRY_CNT, n + 1);
    end
    flt();
    chk("trip", f_trip, 1'b1);
    cyc(2);
    chk("irq", irq, 1'b1);
    wr(ADDR_IRQ_EN, 32'h0000_0000);
    rd(ADDR_IRQ_STAT, 32'h0000_000C);
    wr(ADDR_IRQ_EN, 32'h0000_0008);
    cyc(2);
    chk("irq", irq, 1'b1);
    wr(ADDR_IRQ_CLR, 32'h0000_0008);
    cyc(2);
    chk("irq", irq, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    chk("trip", f_trip, 1'b0);
    rd(ADDR_RETRY_CNT, 0);
    flt();
    chk("reset_pulse", f_rst, 1'b1);
    cyc(5900 * TC);
    rd(ADDR_RETRY_CNT, 1);
    cyc(110 * TC);
    rd(ADDR_RETRY_CNT, 0);
    wr(ADDR_RETRY, 0);
    flt();
    chk("trip", f_trip, 1'b1);
    chk("trip_wait", w <= 8, 1'b1);
    wr(ADDR_CTRL, 32'h0000_0001);
    run_cmd <= 1'b0;
    for (n = 0; n < 6; n++) begin
      wr(ADDR_CHANNEL, n);
      sw_req <= n < 5 ? 5'h01 << n : 5'h1F;
      cyc(6);
      chk("switch", m_sw, n < 5);
      sw_req <= ~(5'h01 << n);
      cyc(6);
      chk("switch", m_sw, 1'b0);
    end
    for (n = 0; n < 2; n++) begin
      run_cmd <= 1'b0;
      cyc(6);
      wr(ADDR_CHANNEL, n << 4);
      sw_req <= 5'h01;
      cyc(6);
      run_cmd <= 1'b1;
      cyc(6);
      sw_req <= 5'h00;
      cyc(6);
      chk("switch_run", m_sw, n == 0);
    end
    conclude();
  end
endmodule : freq_level_detect_fault_retry_tb_top
